// ==== rrsso_pkg.sv ====
// Package: opcodes, states, APB map and reset values for the exit/rotate/subtract/sleep unit
package rrsso_pkg;

    localparam int RRSSO_DATA_W = 8;
    localparam int RRSSO_PC_W = 11;

    typedef enum logic [2:0] {
        RRSSO_OP_NONE = 3'b000,
        RRSSO_OP_RETURN = 3'b001,
        RRSSO_OP_LITERAL_EXIT = 3'b010,
        RRSSO_OP_ROT_LEFT = 3'b011,
        RRSSO_OP_ROT_RIGHT = 3'b100,
        RRSSO_OP_LIT_MINUS = 3'b101,
        RRSSO_OP_SLEEP = 3'b110
    } rrsso_op_e;

    typedef enum logic [1:0] {
        RRSSO_ST_IDLE = 2'b00,
        RRSSO_ST_EXIT2 = 2'b01,
        RRSSO_ST_SLEEP = 2'b10
    } rrsso_state_e;

    // APB register byte offsets
    localparam logic [7:0] RRSSO_OFS_CMD = 8'h00;
    localparam logic [7:0] RRSSO_OFS_WORK = 8'h04;
    localparam logic [7:0] RRSSO_OFS_FILE = 8'h08;
    localparam logic [7:0] RRSSO_OFS_STATUS = 8'h0c;
    localparam logic [7:0] RRSSO_OFS_PC = 8'h10;
    localparam logic [7:0] RRSSO_OFS_STACK = 8'h14;
    localparam logic [7:0] RRSSO_OFS_WAKE = 8'h18;

    // Command register fields
    localparam int RRSSO_CMD_LIT_LSB = 0;
    localparam int RRSSO_CMD_OP_LSB = 8;
    localparam int RRSSO_CMD_DEST_BIT = 12;

    // Status register fields
    localparam int RRSSO_ST_C_BIT = 0;
    localparam int RRSSO_ST_DC_BIT = 1;
    localparam int RRSSO_ST_Z_BIT = 2;
    localparam int RRSSO_ST_PD_BIT = 3;
    localparam int RRSSO_ST_TO_BIT = 4;
    localparam int RRSSO_ST_BUSY_BIT = 5;
    localparam int RRSSO_ST_SLEEP_BIT = 6;

    localparam int RRSSO_EXIT_CYCLES = 2;
    localparam logic [7:0] RRSSO_WORK_RST = 8'h00;
    localparam logic [7:0] RRSSO_WDT_CLEAR = 8'h00;

endpackage

// ==== rrsso_stack.sv ====
// Hardware return stack: small memory with registered head output
module rrsso_stack
    import rrsso_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int WIDTH = 11
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Push and pop
    input wire logic push_in,
    input wire logic [WIDTH-1:0] push_data_in,
    input wire logic pop_in,
    // Head entry and stack level
    output logic [WIDTH-1:0] head_out,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] level_reg;
    logic [WIDTH-1:0] head_reg;
    logic [PW-1:0] below_idx;

    assign below_idx = PW'(level_reg - 2'd2);

    always_ff @(posedge clk_in) begin
        if (push_in) begin
            mem[level_reg[PW-1:0]] <= push_data_in;
        end
    end

    // Head register follows the newest entry so a pop sees it without a read delay
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            level_reg <= '0;
            head_reg <= '0;
        end else if (push_in && level_reg < (PW+1)'(DEPTH)) begin
            level_reg <= level_reg + 1'b1;
            head_reg <= push_data_in;
        end else if (pop_in && level_reg != '0) begin
            level_reg <= level_reg - 1'b1;
            head_reg <= (level_reg > (PW+1)'(1)) ? mem[below_idx] : '0;
        end
    end

    assign head_out = head_reg;
    assign level_out = level_reg;
endmodule

// ==== rrsso_core.sv ====
// Execution unit for the two exits, rotates, literal subtract and sleep entry
// Summary of operation
// RULE1 - Plain exit pops stack into PC, two cycles
// RULE2 - Literal exit loads literal to W, two cycles
// RULE3 - Left rotate: carry into bit0, bit7 out
// RULE4 - Right rotate: carry into bit7, bit0 out
// RULE5 - Destination bit selects W or file register
// RULE6 - Literal minus W written into W
// RULE7 - Carry and half carry clear on borrow
// RULE8 - Sleep clears watchdog counter and prescaler
// RULE9 - Sleep clears power-down flag, sets expiry flag
// RULE10 - Sleep halts core and stops oscillator
// RULE11 - Zero flag follows subtract result
module rrsso_core
    import rrsso_pkg::*;
#(
    parameter int STACK_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Watchdog and clock control
    output logic wdt_clear_out,
    output logic [7:0] watchdog_counter_out,
    output logic osc_run_out,
    // Program counter load
    output logic pc_load_out,
    output logic [RRSSO_PC_W-1:0] pc_out
);
    typedef struct packed {
        rrsso_state_e state;
        logic [7:0] work;
        logic [7:0] file;
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic power_down_flag_n;
        logic watchdog_expiry_flag_n;
        logic [7:0] watchdog_counter;
        logic [7:0] wdt_prescale;
        logic [RRSSO_PC_W-1:0] pc;
        logic pc_load;
        logic wdt_clear;
        logic osc_run;
        logic pop;
        logic push;
        logic [RRSSO_PC_W-1:0] push_data;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } rrsso_core_s;

    rrsso_core_s st_reg;
    rrsso_core_s st_next;

    logic [RRSSO_PC_W-1:0] stack_head_entry;
    logic [$clog2(STACK_DEPTH):0] stack_level;

    rrsso_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(RRSSO_PC_W)
    ) u_stack (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .push_in(st_reg.push),
        .push_data_in(st_reg.push_data),
        .pop_in(st_reg.pop),
        .head_out(stack_head_entry),
        .level_out(stack_level)
    );

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic apb_setup;
    logic apb_access;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic [7:0] literal;
    rrsso_op_e op;
    logic dest;
    logic [7:0] rot_res;
    logic rot_carry;

    assign apb_setup = psel_in && !penable_in;
    assign apb_access = psel_in && penable_in && st_reg.ready;
    assign literal = pwdata_in[RRSSO_CMD_LIT_LSB +: 8];
    assign op = rrsso_op_e'(pwdata_in[RRSSO_CMD_OP_LSB +: 3]);
    assign dest = pwdata_in[RRSSO_CMD_DEST_BIT];
    assign diff = {1'b0, literal} - {1'b0, st_reg.work};
    assign diff_lo = {1'b0, literal[3:0]} - {1'b0, st_reg.work[3:0]};

    always_comb begin
        rot_res = st_reg.file;
        rot_carry = st_reg.carry;
        if (op == RRSSO_OP_ROT_LEFT) begin
            rot_res = {st_reg.file[6:0], st_reg.carry}; // [RULE3]
            rot_carry = st_reg.file[7]; // [RULE3]
        end else if (op == RRSSO_OP_ROT_RIGHT) begin
            rot_res = {st_reg.carry, st_reg.file[7:1]}; // [RULE4]
            rot_carry = st_reg.file[0]; // [RULE4]
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.pc_load = 1'b0;
        st_next.wdt_clear = 1'b0;
        st_next.pop = 1'b0;
        st_next.push = 1'b0;
        st_next.slverr = 1'b0;
        // Answer one cycle after setup; the access phase is then held exactly one cycle
        st_next.ready = apb_setup;

        // Watchdog counts only while osc_run is set; its own timeout logic lives outside this unit
        if (st_reg.osc_run) begin
            st_next.wdt_prescale = st_reg.wdt_prescale + 8'h01;
            if (st_reg.wdt_prescale == 8'hff) begin
                st_next.watchdog_counter = st_reg.watchdog_counter + 8'h01;
            end
        end

        unique case (st_reg.state)
            RRSSO_ST_IDLE: begin
            end
            RRSSO_ST_EXIT2: begin
                // Second cycle of an exit: PC takes the head entry and the stack pops
                st_next.pc = stack_head_entry; // [RULE1] [RULE2]
                st_next.pc_load = 1'b1; // [RULE1] [RULE2]
                st_next.pop = 1'b1; // [RULE1]
                st_next.state = RRSSO_ST_IDLE;
            end
            RRSSO_ST_SLEEP: begin
                st_next.osc_run = 1'b0; // [RULE10]
            end
            default: begin
                st_next.state = RRSSO_ST_IDLE;
            end
        endcase

        if (apb_setup) begin
            st_next.rdata = 32'h0000_0000;
            if (!pwrite_in) begin
                if (addr_is(paddr_in, RRSSO_OFS_WORK)) begin
                    st_next.rdata = {24'h00_0000, st_reg.work};
                end else if (addr_is(paddr_in, RRSSO_OFS_FILE)) begin
                    st_next.rdata = {24'h00_0000, st_reg.file};
                end else if (addr_is(paddr_in, RRSSO_OFS_STATUS)) begin
                    st_next.rdata[RRSSO_ST_C_BIT] = st_reg.carry;
                    st_next.rdata[RRSSO_ST_DC_BIT] = st_reg.half_carry_flag;
                    st_next.rdata[RRSSO_ST_Z_BIT] = st_reg.zero;
                    st_next.rdata[RRSSO_ST_PD_BIT] = st_reg.power_down_flag_n;
                    st_next.rdata[RRSSO_ST_TO_BIT] = st_reg.watchdog_expiry_flag_n;
                    st_next.rdata[RRSSO_ST_BUSY_BIT] = st_reg.state == RRSSO_ST_EXIT2;
                    st_next.rdata[RRSSO_ST_SLEEP_BIT] = st_reg.state == RRSSO_ST_SLEEP;
                end else if (addr_is(paddr_in, RRSSO_OFS_PC)) begin
                    st_next.rdata = {21'h00_0000, st_reg.pc};
                end else if (addr_is(paddr_in, RRSSO_OFS_STACK)) begin
                    st_next.rdata = {16'h0000, 3'h0, 2'h0, stack_head_entry};
                    st_next.rdata[31:24] = 8'(stack_level);
                end else if (!addr_is(paddr_in, RRSSO_OFS_CMD)
                             && !addr_is(paddr_in, RRSSO_OFS_WAKE)) begin
                    st_next.slverr = 1'b1;
                end
            end else if (!(addr_is(paddr_in, RRSSO_OFS_CMD) || addr_is(paddr_in, RRSSO_OFS_WORK)
                           || addr_is(paddr_in, RRSSO_OFS_FILE)
                           || addr_is(paddr_in, RRSSO_OFS_STACK)
                           || addr_is(paddr_in, RRSSO_OFS_WAKE))) begin
                st_next.slverr = 1'b1;
            end
        end

        // Writes take effect on the access edge, a stack push one edge later; a command or W/file write during an exit or sleep is ignored
        if (apb_access && pwrite_in) begin
            if (addr_is(paddr_in, RRSSO_OFS_WORK) && st_reg.state == RRSSO_ST_IDLE) begin
                st_next.work = pwdata_in[7:0];
            end else if (addr_is(paddr_in, RRSSO_OFS_FILE) && st_reg.state == RRSSO_ST_IDLE) begin
                st_next.file = pwdata_in[7:0];
            end else if (addr_is(paddr_in, RRSSO_OFS_STACK)) begin
                st_next.push = 1'b1;
                st_next.push_data = pwdata_in[RRSSO_PC_W-1:0];
            end else if (addr_is(paddr_in, RRSSO_OFS_WAKE) && st_reg.state == RRSSO_ST_SLEEP) begin
                st_next.osc_run = 1'b1;
                st_next.state = RRSSO_ST_IDLE;
            end else if (addr_is(paddr_in, RRSSO_OFS_CMD) && st_reg.state == RRSSO_ST_IDLE) begin
                unique case (op)
                    RRSSO_OP_RETURN: begin
                        st_next.state = RRSSO_ST_EXIT2; // [RULE1]
                    end
                    RRSSO_OP_LITERAL_EXIT: begin
                        st_next.work = literal; // [RULE2]
                        st_next.state = RRSSO_ST_EXIT2; // [RULE2]
                    end
                    RRSSO_OP_ROT_LEFT, RRSSO_OP_ROT_RIGHT: begin
                        st_next.carry = rot_carry; // [RULE3] [RULE4]
                        if (dest) begin
                            st_next.file = rot_res; // [RULE5]
                        end else begin
                            st_next.work = rot_res; // [RULE5]
                        end
                    end
                    RRSSO_OP_LIT_MINUS: begin
                        st_next.work = diff[7:0]; // [RULE6]
                        st_next.carry = ~diff[8]; // [RULE7]
                        st_next.half_carry_flag = ~diff_lo[4]; // [RULE7]
                        st_next.zero = diff[7:0] == 8'h00; // [RULE11]
                    end
                    RRSSO_OP_SLEEP: begin
                        st_next.watchdog_counter = RRSSO_WDT_CLEAR; // [RULE8]
                        st_next.wdt_prescale = 8'h00; // [RULE8]
                        st_next.wdt_clear = 1'b1; // [RULE8]
                        st_next.power_down_flag_n = 1'b0; // [RULE9]
                        st_next.watchdog_expiry_flag_n = 1'b1; // [RULE9]
                        // Stop at once so the cleared prescaler cannot tick on the way in
                        st_next.osc_run = 1'b0; // [RULE10]
                        st_next.state = RRSSO_ST_SLEEP; // [RULE10]
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_reg <= '0;
            st_reg.state <= RRSSO_ST_IDLE;
            st_reg.work <= RRSSO_WORK_RST;
            st_reg.power_down_flag_n <= 1'b1;
            st_reg.watchdog_expiry_flag_n <= 1'b1;
            st_reg.osc_run <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata_out = st_reg.rdata;
    assign pready_out = st_reg.ready;
    assign pslverr_out = st_reg.slverr;
    assign wdt_clear_out = st_reg.wdt_clear;
    assign watchdog_counter_out = st_reg.watchdog_counter;
    assign osc_run_out = st_reg.osc_run;
    assign pc_load_out = st_reg.pc_load;
    assign pc_out = st_reg.pc;
endmodule

// ==== rrsso_chk_sva.sv ====
// Port-level checker for the exit, rotate, subtract and sleep unit
module rrsso_chk
    import rrsso_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Core side
    input wire logic wdt_clear_out,
    input wire logic [7:0] watchdog_counter_out,
    input wire logic osc_run_out,
    input wire logic pc_load_out,
    input wire logic [RRSSO_PC_W-1:0] pc_out
);
    default clocking dflt @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wire acc = psel_in && penable_in && pwrite_in && pready_out;
    // Commands while asleep are dropped, so they are left out here, as are those in the PC load cycle after an exit
    wire cmd = acc && paddr_in == RRSSO_OFS_CMD && osc_run_out && !pc_load_out;
    wire wake = acc && paddr_in == RRSSO_OFS_WAKE;
    wire [2:0] op = pwdata_in[10:8];
    sequence exit_cmd;
        cmd && (op == RRSSO_OP_RETURN || op == RRSSO_OP_LITERAL_EXIT);
    endsequence
    sequence sleep_cmd;
        cmd && op == RRSSO_OP_SLEEP;
    endsequence
    sequence sleep_entry;
        wdt_clear_out && !osc_run_out ##1 !wdt_clear_out && watchdog_counter_out == 8'h00;
    endsequence
    ready_follow_a: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    exit_load_a: assert property (exit_cmd |=> !pc_load_out ##1 pc_load_out ##1 !pc_load_out)
        else $error("exit did not load pc once");
    pc_only_load_a: assert property ($changed(pc_out) |-> pc_load_out)
        else $error("pc moved without load");
    sleep_entry_a: assert property (sleep_cmd |=> sleep_entry)
        else $error("sleep entry wrong");
    sleep_hold_a: assert property (!osc_run_out && !wake |=> !osc_run_out)
        else $error("oscillator restarted without wake");
    wdt_still_a: assert property (!osc_run_out && watchdog_counter_out == 8'h00 |=>
        watchdog_counter_out == 8'h00)
        else $error("watchdog counted while asleep");
    wdt_pulse_a: assert property (wdt_clear_out |=> !wdt_clear_out)
        else $error("watchdog clear held");
endmodule

// ==== tb_return_rotate_sublit_sleep_ops.sv ====
// Self-checking bench for the exit, rotate, subtract and sleep unit
module tb_return_rotate_sublit_sleep_ops
    import rrsso_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, wdt_clear_out, osc_run_out, pc_load_out;
    logic [7:0] watchdog_counter_out;
    logic [RRSSO_PC_W-1:0] pc_out;
    logic [7:0] m_w = 8'h00, m_f = 8'h00;
    logic m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0;
    logic [15:0] sv [5] = '{16'h1005, 16'h0510, 16'h2001, 16'hff00, 16'h3333};
    logic [31:0] r;
    logic e;
    int n_mismatch = 0;
    int n_tests = 0;
    rrsso_core dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .wdt_clear_out(wdt_clear_out), .watchdog_counter_out(watchdog_counter_out),
        .osc_run_out(osc_run_out), .pc_load_out(pc_load_out), .pc_out(pc_out)
    );
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Each transfer opens on a fresh edge, so no signal is driven twice in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    function automatic logic [31:0] stat(input logic slp);
        return {25'h0, slp, 1'b0, 1'b1, !slp, m_z, m_dc, m_c};
    endfunction
    task automatic cmd(input logic [2:0] op, input logic [7:0] k, input logic d);
        xfer(1'b1, RRSSO_OFS_CMD, {19'h0, d, 1'b0, op, k});
    endtask
    task automatic run_op(input logic [2:0] op, input logic [7:0] k, input logic d);
        logic [7:0] v;
        cmd(op, k, d);
        if (op == RRSSO_OP_ROT_LEFT) begin
            v = {m_f[6:0], m_c};
            m_c = m_f[7];
        end else if (op == RRSSO_OP_ROT_RIGHT) begin
            v = {m_c, m_f[7:1]};
            m_c = m_f[0];
        end else begin
            v = k - m_w;
            m_c = m_w <= k;
            m_dc = m_w[3:0] <= k[3:0];
            m_z = v == 8'h00;
        end
        if (d && op != RRSSO_OP_LIT_MINUS) m_f = v;
        else m_w = v;
        rdc(RRSSO_OFS_WORK, {24'h0, m_w});
        rdc(RRSSO_OFS_FILE, {24'h0, m_f});
        rdc(RRSSO_OFS_STATUS, stat(1'b0));
    endtask
    task automatic exit_chk(input logic [10:0] pc);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pc_load_out !== 1'b1 && n < 5);
        chk({20'h0, pc_load_out, pc_out}, {20'h0, 1'b1, pc});
        chk(n, RRSSO_EXIT_CYCLES);
    endtask
    initial begin
        repeat (4000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rdc(RRSSO_OFS_STATUS, stat(1'b0));
        foreach (sv[i]) begin
            xfer(1'b1, RRSSO_OFS_WORK, {24'h0, sv[i][7:0]});
            m_w = sv[i][7:0];
            run_op(RRSSO_OP_LIT_MINUS, sv[i][15:8], 1'b1);
        end
        xfer(1'b1, RRSSO_OFS_FILE, 32'he6);
        m_f = 8'he6;
        run_op(RRSSO_OP_ROT_LEFT, 8'h00, 1'b0);
        run_op(RRSSO_OP_ROT_RIGHT, 8'h00, 1'b1);
        run_op(RRSSO_OP_ROT_LEFT, 8'h00, 1'b1);
        run_op(RRSSO_OP_ROT_RIGHT, 8'h00, 1'b0);
        xfer(1'b1, RRSSO_OFS_STACK, 32'h123);
        rdc(RRSSO_OFS_STACK, 32'h0100_0123);
        cmd(RRSSO_OP_RETURN, 8'h00, 1'b0);
        exit_chk(11'h123);
        rdc(RRSSO_OFS_STATUS, stat(1'b0));
        xfer(1'b1, RRSSO_OFS_STACK, 32'h2aa);
        cmd(RRSSO_OP_LITERAL_EXIT, 8'ha5, 1'b0);
        exit_chk(11'h2aa);
        m_w = 8'ha5;
        rdc(RRSSO_OFS_WORK, 32'ha5);
        rdc(RRSSO_OFS_STATUS, stat(1'b0));
        xfer(1'b0, 8'h1c, 32'h0);
        chk({31'h0, e}, 32'h1);
        xfer(1'b1, RRSSO_OFS_STATUS, 32'h0);
        chk({31'h0, e}, 32'h1);
        repeat (600) @(posedge clk_in);
        chk({31'h0, watchdog_counter_out != 8'h00}, 32'h1);
        cmd(RRSSO_OP_SLEEP, 8'h00, 1'b0);
        rdc(RRSSO_OFS_STATUS, stat(1'b1));
        chk({23'h0, osc_run_out, watchdog_counter_out}, 32'h0);
        xfer(1'b1, RRSSO_OFS_WORK, 32'h5a);
        rdc(RRSSO_OFS_WORK, {24'h0, m_w});
        repeat (300) @(posedge clk_in);
        chk({23'h0, osc_run_out, watchdog_counter_out}, 32'h0);
        xfer(1'b1, RRSSO_OFS_WAKE, 32'h1);
        @(posedge clk_in);
        chk({31'h0, osc_run_out}, 32'h1);
        summarize();
    end
endmodule
bind rrsso_core rrsso_chk chk_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .wdt_clear_out(wdt_clear_out), .watchdog_counter_out(watchdog_counter_out),
    .osc_run_out(osc_run_out), .pc_load_out(pc_load_out), .pc_out(pc_out)
);
